/* verilog/frd_defines.svh */
// Purpose: opcodes, frame points and timing figures of the flash command block
// Assumes: single-bit opcode phase, counts are rising clock edges in a frame
// Notes:   times are in ns; cycle counts are derived inside the module
`ifndef FRD_DEFINES_SVH
`define FRD_DEFINES_SVH

// instruction codes
`define FRD_OP_RESUME    8'h7a
`define FRD_OP_SUSPEND   8'h75
`define FRD_OP_PDOWN     8'hb9
`define FRD_OP_RELEASE   8'hab
`define FRD_OP_MDID      8'h90
`define FRD_OP_MDID_X2   8'h92
`define FRD_OP_MDID_X4   8'h94
`define FRD_OP_UID       8'h4b

// edge index of the last opcode bit
`define FRD_OP_BITS      7'h08
// edge index of the last address or dummy clock, output starts after it
`define FRD_LD_RELEASE   7'h20
`define FRD_LD_MDID      7'h20
`define FRD_LD_MDID_X2   7'h18
`define FRD_LD_MDID_X4   7'h14
`define FRD_LD_UID       7'h28
// edge index that carries address bit 0 on io0
`define FRD_A0_MDID      7'h20
`define FRD_A0_MDID_X2   7'h14
`define FRD_A0_MDID_X4   7'h12

// timing
`define FRD_CLK_NS       20
`define FRD_RES_BUSY_NS  200
`define FRD_DP_NS        3000
`define FRD_RES1_NS      3000
`define FRD_RES2_NS      3000

`endif

/* verilog/frd_pkg.sv */
// Purpose: types shared by the flash command block
// Assumes: frd_defines.svh holds all numbers
// Notes:   enums carry no codes on purpose
package frd_pkg;

    // power state of the core side
    typedef enum logic [1:0] {FRD_RUN, FRD_PD_ENTER, FRD_PD, FRD_WAKE} frd_pwr_t;

    // lane width of the current frame
    typedef enum logic [1:0] {FRD_X1, FRD_X2, FRD_X4} frd_wid_t;

    // driven side of the four io pins
    typedef struct packed {
        logic [3:0] oe;
        logic [3:0] dout;
    } frd_io_t;

    // status seen by the erase/program engine and the rest of the chip
    typedef struct packed {
        logic suspend_status_flag;
        logic busy;
        logic pdown;
        logic sus_req;
        logic res_req;
    } frd_stat_t;

    // link-side state, clocked by the serial clock
    typedef struct packed {
        logic [7:0]  op;
        logic [6:0]  cnt;
        logic        a0;
        logic [63:0] sh;
        frd_wid_t    wid;
        logic        tx;
        logic [1:0]  blk_s;
        logic [1:0]  busy_s;
    } frd_link_t;

    // core-side state
    typedef struct packed {
        frd_pwr_t    st;
        logic [15:0] tmr;
        logic [2:0]  cs_s;
        logic        suspend_status_flag;
        logic        busy;
        logic        sus_req;
        logic        res_req;
        logic        blk;
        logic        pd;
    } frd_core_t;

endpackage

/* verilog/frd_cmd.sv */
// Purpose: command handling for resume, suspend, power-down and id reads
// Assumes: host runs spi mode 0; engine raises eng_busy one cycle after res_req
// Notes:   link logic runs on sck; frame end is seen on the core side via cs_n
`timescale 1ns/1ps
`include "frd_defines.svh"

// Overview of operation
// - resume needs suspend flag set, not busy
// - resume clears suspend, raises busy quickly
// - otherwise resume is ignored, state kept
// - power loss clears suspend, resume then ignored
// - power-down only with exactly eight bits
// - power-down entered within entry time
// - in power-down only release is recognised
// - start in normal operation after power-up
// - plain release, recovery time, then accept
// - release plus dummies streams device id
// - release with id waits its own recovery
// - release/id ignored while busy
// - id read: zero address, maker then device
// - dual id read, two bits per clock
// - address one swaps order, ids alternate
// - quad id read: dummies, four bits/clock
// - unique id: four dummy bytes, 64 bits
// - accepted suspend sets flag, busy drops
// - suspend only in sector/block erase, program
module frd_cmd #(
    parameter logic [7:0]  MFR_ID  = 8'h5a,  // arbitrary value
    parameter logic [7:0]  DEV_ID  = 8'h14,  // arbitrary value
    parameter logic [63:0] UID     = 64'h0123456789abcdef,  // arbitrary value
    parameter int          DP_NS   = `FRD_DP_NS,
    parameter int          RES1_NS = `FRD_RES1_NS,
    parameter int          RES2_NS = `FRD_RES2_NS
) (
    input  wire logic          core_clk,
    input  wire logic          nrst,
    input  wire logic          sck,
    input  wire logic          cs_n,
    input  wire logic [3:0]    io_in,
    output frd_pkg::frd_io_t   io_out,
    input  wire logic          eng_busy,
    input  wire logic          eng_chip,
    output frd_pkg::frd_stat_t status
);
    import frd_pkg::*;

    localparam int DP_CYC   = DP_NS / `FRD_CLK_NS;
    localparam int RES1_CYC = RES1_NS / `FRD_CLK_NS;
    localparam int RES2_CYC = RES2_NS / `FRD_CLK_NS;
    localparam int RB_CYC   = `FRD_RES_BUSY_NS / `FRD_CLK_NS;
    localparam int WAKE_MAX = (RES1_CYC > RES2_CYC) ? RES1_CYC : RES2_CYC;

    // timers are 16 bits wide
    if (DP_CYC < 1 || RES1_CYC < 1 || RES2_CYC < 1 || WAKE_MAX > 65536 ||
        DP_CYC > 65536) begin : g_bad_time
        $error("frd_cmd: timing parameters out of range");
    end

    frd_link_t l_q;
    frd_link_t l_d;
    frd_core_t c_q;
    frd_core_t c_d;
    frd_io_t   o_q;
    frd_io_t   o_d;
    logic      frame_q;
    logic [6:0] n;
    logic [7:0] opn;
    logic [3:0] inb;
    logic [6:0] ld_pt;
    logic      ok;
    logic      rise;
    logic      one8;

    // frame marker: cleared while cs_n is high, so the next edge starts at 1
    always_ff @(posedge sck or posedge cs_n or negedge nrst) begin
        if (!nrst) begin
            frame_q <= 1'b0;
        end else if (cs_n) begin
            frame_q <= 1'b0;
        end else begin
            frame_q <= 1'b1;
        end
    end

    // link decode: opcode shift, address bit 0 capture, id stream
    always_comb begin
        l_d        = l_q;
        l_d.blk_s  = {l_q.blk_s[0], c_q.blk};
        l_d.busy_s = {l_q.busy_s[0], c_q.busy};
        n          = frame_q ? ((l_q.cnt == 7'h7f) ? l_q.cnt : l_q.cnt + 7'h01) : 7'h01;
        opn        = {l_q.op[6:0], io_in[0]};
        unique case (l_q.wid)
            FRD_X2:  inb = {2'b00, io_in[1:0]};
            FRD_X4:  inb = io_in;
            default: inb = {3'b000, io_in[0]};
        endcase
        unique case (l_q.op)
            `FRD_OP_RELEASE: ld_pt = `FRD_LD_RELEASE;
            `FRD_OP_MDID:    ld_pt = `FRD_LD_MDID;
            `FRD_OP_MDID_X2: ld_pt = `FRD_LD_MDID_X2;
            `FRD_OP_MDID_X4: ld_pt = `FRD_LD_MDID_X4;
            `FRD_OP_UID:     ld_pt = `FRD_LD_UID;
            default:         ld_pt = 7'h00;
        endcase
        ok = (!l_q.blk_s[1] || l_q.op == `FRD_OP_RELEASE) && !l_q.busy_s[1];
        l_d.cnt = n;
        if (n <= `FRD_OP_BITS) begin
            l_d.op = opn;
            l_d.tx = 1'b0;
            if (n == 7'h01) begin
                l_d.wid = FRD_X1;
            end
            if (n == `FRD_OP_BITS) begin
                l_d.wid = (opn == `FRD_OP_MDID_X2) ? FRD_X2 :
                          (opn == `FRD_OP_MDID_X4) ? FRD_X4 : FRD_X1;
            end
        end else if (l_q.tx) begin
            // rotate so the ids repeat until cs_n rises
            unique case (l_q.wid)
                FRD_X2:  l_d.sh = {l_q.sh[61:0], l_q.sh[63:62]};
                FRD_X4:  l_d.sh = {l_q.sh[59:0], l_q.sh[63:60]};
                default: l_d.sh = {l_q.sh[62:0], l_q.sh[63]};
            endcase
        end else begin
            // address bit 0 chooses which id leads
            if ((l_q.op == `FRD_OP_MDID && n == `FRD_A0_MDID) ||
                (l_q.op == `FRD_OP_MDID_X2 && n == `FRD_A0_MDID_X2) ||
                (l_q.op == `FRD_OP_MDID_X4 && n == `FRD_A0_MDID_X4)) begin
                l_d.a0 = inb[0];
            end
            if (n == ld_pt && ok) begin
                l_d.tx = 1'b1;
                unique case (l_q.op)
                    `FRD_OP_RELEASE: l_d.sh = {8{DEV_ID}};
                    `FRD_OP_UID:     l_d.sh = UID;
                    default: l_d.sh = l_d.a0 ? {4{DEV_ID, MFR_ID}} : {4{MFR_ID, DEV_ID}};
                endcase
            end
        end
    end

    // link registers, reset by the chip reset only so the core can read them
    always_ff @(posedge sck or negedge nrst) begin
        if (!nrst) begin
            l_q <= '{op: 8'h00, cnt: 7'h00, a0: 1'b0, sh: 64'h0, wid: FRD_X1,
                     tx: 1'b0, blk_s: 2'b00, busy_s: 2'b00};
        end else begin
            l_q <= l_d;
        end
    end

    // pin drive, updated on falling edges; msb leaves first
    always_comb begin
        o_d = '{oe: 4'h0, dout: 4'h0};
        if (l_q.tx) begin
            unique case (l_q.wid)
                FRD_X2:  o_d = '{oe: 4'h3, dout: {2'b00, l_q.sh[63:62]}};
                FRD_X4:  o_d = '{oe: 4'hf, dout: l_q.sh[63:60]};
                default: o_d = '{oe: 4'h2, dout: {2'b00, l_q.sh[63], 1'b0}};
            endcase
        end
    end

    // release pins at once when cs_n rises; sck may stop then
    always_ff @(negedge sck or posedge cs_n or negedge nrst) begin
        if (!nrst) begin
            o_q <= '{oe: 4'h0, dout: 4'h0};
        end else if (cs_n) begin
            o_q <= '{oe: 4'h0, dout: 4'h0};
        end else begin
            o_q <= o_d;
        end
    end

    // op and cnt are still when cs_n is high, so the synced rise qualifies them
    assign rise = c_q.cs_s[1] & ~c_q.cs_s[2];
    // act only on exactly eight bits
    assign one8 = rise && l_q.cnt == `FRD_OP_BITS;

    // core command execution at frame end
    always_comb begin
        c_d         = c_q;
        c_d.cs_s    = {c_q.cs_s[1], c_q.cs_s[0], cs_n};
        c_d.sus_req = 1'b0;
        c_d.res_req = 1'b0;
        // busy follows the engine; the resume pulse covers its one-cycle lag
        c_d.busy    = eng_busy | c_q.res_req;
        unique case (c_q.st)
            FRD_RUN: begin
                if (one8) begin
                    unique case (l_q.op)
                        `FRD_OP_RESUME: begin
                            if (c_q.suspend_status_flag && !c_q.busy) begin
                                c_d.suspend_status_flag     = 1'b0;
                                c_d.res_req = 1'b1;
                                c_d.busy    = 1'b1;
                            end
                        end
                        `FRD_OP_SUSPEND: begin
                            if (!c_q.suspend_status_flag && c_q.busy && !eng_chip) begin
                                c_d.suspend_status_flag     = 1'b1;
                                c_d.sus_req = 1'b1;
                            end
                        end
                        `FRD_OP_PDOWN: begin
                            c_d.st  = FRD_PD_ENTER;
                            c_d.tmr = 16'(DP_CYC - 1);
                        end
                        default: ;
                    endcase
                end
            end
            FRD_PD_ENTER: begin
                if (c_q.tmr == 16'h0000) begin
                    c_d.st = FRD_PD;
                end else begin
                    c_d.tmr = c_q.tmr - 16'h0001;
                end
            end
            FRD_PD: begin
                // not while a cycle is running
                if (rise && l_q.op == `FRD_OP_RELEASE && l_q.cnt >= `FRD_OP_BITS &&
                    !c_q.busy) begin
                    c_d.st  = FRD_WAKE;
                    c_d.tmr = (l_q.cnt == `FRD_OP_BITS) ? 16'(RES1_CYC - 1) :
                                                          16'(RES2_CYC - 1);
                end
            end
            FRD_WAKE: begin
                if (c_q.tmr == 16'h0000) begin
                    c_d.st = FRD_RUN;
                end else begin
                    c_d.tmr = c_q.tmr - 16'h0001;
                end
            end
        endcase
        c_d.blk = (c_d.st != FRD_RUN);
        c_d.pd  = (c_d.st == FRD_PD);
    end

    // reset lands in run with suspend clear
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            c_q <= '{st: FRD_RUN, tmr: 16'h0000, cs_s: 3'b111, suspend_status_flag: 1'b0, busy: 1'b0,
                     sus_req: 1'b0, res_req: 1'b0, blk: 1'b0, pd: 1'b0};
        end else begin
            c_q <= c_d;
        end
    end

    assign io_out = o_q;
    assign status = '{suspend_status_flag: c_q.suspend_status_flag, busy: c_q.busy, pdown: c_q.pd,
                      sus_req: c_q.sus_req, res_req: c_q.res_req};

    // first cycle after reset, for the power-up check
    logic first_q;
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            first_q <= 1'b1;
        end else begin
            first_q <= 1'b0;
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!nrst);

    AST_RESUME_GATE: assert property (
        c_q.res_req |-> $past(c_q.suspend_status_flag) && !$past(c_q.busy) && !c_q.suspend_status_flag)
        else $error("resume taken without suspend or while busy");

    AST_RESUME_BUSY: assert property (
        $rose(c_q.res_req) |-> ##[1:RB_CYC] c_q.busy)
        else $error("busy not raised after resume");

    AST_RESUME_IGNORE: assert property (
        one8 && c_q.st == FRD_RUN && l_q.op == `FRD_OP_RESUME && (!c_q.suspend_status_flag || c_q.busy)
        |=> !c_q.res_req && c_q.suspend_status_flag == $past(c_q.suspend_status_flag))
        else $error("resume not ignored");

    AST_PWRUP_RUN: assert property (
        first_q |-> c_q.st == FRD_RUN && !c_q.suspend_status_flag && !status.pdown)
        else $error("not in normal operation after reset");

    AST_PD_SHORT: assert property (
        c_q.st == FRD_RUN && rise && l_q.op == `FRD_OP_PDOWN && !one8 |=> c_q.st == FRD_RUN)
        else $error("power-down taken with wrong bit count");

    AST_PD_ENTRY: assert property (
        $rose(c_q.st == FRD_PD_ENTER) |-> ##[1:DP_CYC] c_q.st == FRD_PD)
        else $error("power-down entry too slow");

    AST_PD_ONLY_REL: assert property (
        c_q.st == FRD_PD && !(rise && l_q.op == `FRD_OP_RELEASE) |=> c_q.st == FRD_PD)
        else $error("left power-down without release");

    AST_WAKE_TIME: assert property (
        $rose(c_q.st == FRD_WAKE) |-> c_q.blk ##[1:WAKE_MAX] c_q.st == FRD_RUN)
        else $error("release recovery not completed in time");

    AST_SUSPEND: assert property (
        c_q.sus_req |-> c_q.suspend_status_flag && !$past(eng_chip) && $past(c_q.busy))
        else $error("suspend taken outside an erase or program");

endmodule // frd_cmd

/* verification/frd_host.sv */
// Purpose: host side of the serial link, sends frames and collects replies
// Assumes: mode 0, sck idles low and stands still between frames
// Notes:   undriven lanes toggle so a stale level never passes for data
`timescale 1ns/1ps
module frd_host (
    output logic             sck,
    output logic             cs_n,
    output logic [3:0]       io_in,
    input  frd_pkg::frd_io_t io_out
);
    import frd_pkg::*;
    logic [3:0]  h_oe;
    logic [3:0]  h_val;
    logic [3:0]  pat;
    logic [63:0] rx;
    logic        rx_oe;

    // idle levels at time zero
    initial begin
        sck = 1'b0;
        cs_n = 1'b1;
        h_oe = 4'h0;
        h_val = 4'h0;
        pat = 4'h5;
    end

    // released lanes change every 5 ns
    always #5 pat = ~pat;

    // pin level: device drive first, then host, else the pattern
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            io_in[i] = io_out.oe[i] ? io_out.dout[i] : (h_oe[i] ? h_val[i] : pat[i]);
        end
    end

    // one frame: n edges, output after edge ld, w lanes
    task automatic frame(input logic [7:0] op, input int n, input int ld, input int w,
                         input int a0e, input logic a0, input int m0, input int m1);
        logic [3:0] msk;
        logic [3:0] s;
        msk = (w == 4) ? 4'hf : ((w == 2) ? 4'h3 : 4'h1);
        rx = '0;
        rx_oe = 1'b0;
        cs_n = 1'b0;
        for (int k = 1; k <= n; k++) begin
            h_oe = (k > ld) ? 4'h0 : ((k <= 8) ? 4'h1 : msk);
            h_val = 4'h0;
            if (k <= 8) h_val[0] = op[8-k];
            // address zero apart from bit 0
            if (k == a0e) h_val[0] = a0;
            if (k >= m0 && k <= m1) h_val = 4'hf;
            #6;
            // read the pin level, so a missing output enable shows the pattern
            s = (w == 1) ? {3'h0, io_in[1]} : (io_in & msk);
            if (k > ld) rx = (rx << w) | {60'h0, s};
            if (k > ld) rx_oe = rx_oe | (|io_out.oe);
            sck = 1'b1;
            #6;
            sck = 1'b0;
        end
        #6;
        // cs_n rises right after the last bit
        cs_n = 1'b1;
        h_oe = 4'h0;
        // cs_n stays high well past the 80 ns gap
        #100;
    endtask
endmodule // frd_host

/* verification/tb_flash_resume_powerdown_id.sv */
// Purpose: self-checking bench of the flash command block
// Assumes: entry and wake times shortened to 100 ns (5 cycles)
// Notes:   a tiny engine stand-in follows the suspend and resume pulses
`timescale 1ns/1ps
module tb_flash_resume_powerdown_id;
    import frd_pkg::*;
    localparam logic [7:0]  MFR  = 8'h3c;                // arbitrary value
    localparam logic [7:0]  DEV  = 8'h27;                // arbitrary value
    localparam logic [63:0] UIDV = 64'h1122334455667788; // arbitrary value
    localparam int          WK   = 5;
    logic      core_clk;
    logic      nrst;
    logic      sck;
    logic      cs_n;
    logic      eng_busy;
    logic      eng_chip;
    logic [3:0] io_in;
    frd_io_t   io_out;
    frd_stat_t status;
    int        miscompares;
    int        checks;
    int        n_res;

    frd_cmd #(.MFR_ID(MFR), .DEV_ID(DEV), .UID(UIDV), .DP_NS(100), .RES1_NS(100),
              .RES2_NS(100)) frd_cmd_inst (.core_clk(core_clk), .nrst(nrst), .sck(sck),
        .cs_n(cs_n), .io_in(io_in), .io_out(io_out), .eng_busy(eng_busy),
        .eng_chip(eng_chip), .status(status));
    frd_host frd_host_inst (.sck(sck), .cs_n(cs_n), .io_in(io_in), .io_out(io_out));

    // 50 MHz core clock
    initial begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end

    // engine stand-in: runs on resume, halts on suspend
    always @(posedge core_clk) begin
        if (status.res_req === 1'b1) eng_busy <= 1'b1;
        if (status.sus_req === 1'b1) eng_busy <= 1'b0;
        if (status.res_req === 1'b1) n_res <= n_res + 1;
    end

    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask

    task automatic cmp_flag(input string nm, input logic e, input logic g);
        checks++;
        if (g !== e) begin
            miscompares++;
            $display("mismatch %s expected %b seen %b", nm, e, g);
        end
    endtask

    task automatic cmp_word(input string nm, input logic [63:0] e, input logic [63:0] g);
        checks++;
        if (g !== e) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask

    // bounded wait on one status bit; running out ends the run
    task automatic wait_bit(input string nm, input int b, input logic v, input int lim);
        int i;
        i = 0;
        while (status[b] !== v && i < lim) begin
            cyc(1);
            i++;
        end
        cmp_flag(nm, v, status[b]);
        if (status[b] !== v) tally_and_finish();
    endtask

    task automatic tally_and_finish();
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic t_suspend_resume();
        eng_busy = 1'b1;
        eng_chip = 1'b1;
        frd_host_inst.frame(8'h75, 8, 8, 1, 0, 1'b0, 0, 0);
        cmp_flag("sus_chip", 1'b0, status.suspend_status_flag);
        cyc(1);
        eng_chip = 1'b0;
        frd_host_inst.frame(8'h75, 8, 8, 1, 0, 1'b0, 0, 0);
        wait_bit("sus_set", 4, 1'b1, 5);
        wait_bit("busy_drop", 3, 1'b0, 5);
        frd_host_inst.frame(8'h7a, 8, 8, 1, 0, 1'b0, 0, 0);
        wait_bit("res_busy", 3, 1'b1, 5);
        cmp_flag("res_sus", 1'b0, status.suspend_status_flag);
        cmp_word("res_cnt", 64'd1, 64'(n_res));
        frd_host_inst.frame(8'h7a, 8, 8, 1, 0, 1'b0, 0, 0);
        cyc(5);
        cmp_word("res_ign", 64'd1, 64'(n_res));
        cmp_flag("res_ign_busy", 1'b1, status.busy);
        $display("test suspend_resume done");
    endtask

    task automatic t_power_loss();
        // hold off the next suspend after a resume
        cyc(20);
        frd_host_inst.frame(8'h75, 8, 8, 1, 0, 1'b0, 0, 0);
        wait_bit("pl_sus", 4, 1'b1, 5);
        cyc(1);
        nrst = 1'b0;
        cyc(3);
        nrst = 1'b1;
        cmp_flag("pl_up", 1'b0, status.pdown);
        frd_host_inst.frame(8'h7a, 8, 8, 1, 0, 1'b0, 0, 0);
        cyc(5);
        cmp_word("pl_res", 64'd1, 64'(n_res));
        cmp_flag("pl_busy", 1'b0, status.busy);
        $display("test power_loss done");
    endtask

    task automatic t_ids();
        frd_host_inst.frame(8'h90, 48, 32, 1, 32, 1'b0, 0, 0);
        cmp_word("id_x1", 64'({MFR, DEV}), frd_host_inst.rx);
        frd_host_inst.frame(8'h92, 36, 24, 2, 20, 1'b1, 21, 22);
        cmp_word("id_x2", 64'({DEV, MFR, DEV}), frd_host_inst.rx);
        frd_host_inst.frame(8'h94, 26, 20, 4, 18, 1'b0, 19, 19);
        cmp_word("id_x4", 64'({MFR, DEV, MFR}), frd_host_inst.rx);
        frd_host_inst.frame(8'h94, 26, 20, 4, 18, 1'b1, 19, 19);
        cmp_word("id_x4_a1", 64'({DEV, MFR, DEV}), frd_host_inst.rx);
        frd_host_inst.frame(8'hab, 48, 32, 1, 0, 1'b0, 0, 0);
        cmp_word("id_rel", 64'({DEV, DEV}), frd_host_inst.rx);
        frd_host_inst.frame(8'h4b, 104, 40, 1, 0, 1'b0, 0, 0);
        cmp_word("id_uniq", UIDV, frd_host_inst.rx);
        $display("test ids done");
    endtask

    task automatic t_power_down();
        frd_host_inst.frame(8'hb9, 9, 8, 1, 0, 1'b0, 0, 0);
        cyc(WK + 3);
        cmp_flag("pd_nine", 1'b0, status.pdown);
        frd_host_inst.frame(8'hb9, 8, 8, 1, 0, 1'b0, 0, 0);
        wait_bit("pd_enter", 2, 1'b1, WK);
        frd_host_inst.frame(8'h90, 48, 32, 1, 32, 1'b0, 0, 0);
        cmp_flag("pd_read", 1'b0, frd_host_inst.rx_oe);
        cmp_flag("pd_stay", 1'b1, status.pdown);
        frd_host_inst.frame(8'hab, 8, 8, 1, 0, 1'b0, 0, 0);
        wait_bit("pd_wake", 2, 1'b0, 3);
        cyc(WK + 2);
        frd_host_inst.frame(8'h90, 48, 32, 1, 32, 1'b0, 0, 0);
        cmp_word("pd_after", 64'({MFR, DEV}), frd_host_inst.rx);
        frd_host_inst.frame(8'hb9, 8, 8, 1, 0, 1'b0, 0, 0);
        wait_bit("pd_enter2", 2, 1'b1, WK);
        frd_host_inst.frame(8'hab, 48, 32, 1, 0, 1'b0, 0, 0);
        cmp_word("pd_relid", 64'({DEV, DEV}), frd_host_inst.rx);
        wait_bit("pd_wake2", 2, 1'b0, 3);
        cyc(WK + 2);
        frd_host_inst.frame(8'h90, 48, 32, 1, 32, 1'b0, 0, 0);
        cmp_word("pd_after2", 64'({MFR, DEV}), frd_host_inst.rx);
        $display("test power_down done");
    endtask

    task automatic t_busy_release();
        cyc(1);
        eng_busy = 1'b1;
        cyc(3);
        frd_host_inst.frame(8'hab, 48, 32, 1, 0, 1'b0, 0, 0);
        cmp_flag("br_drive", 1'b0, frd_host_inst.rx_oe);
        cmp_flag("br_busy", 1'b1, status.busy);
        cmp_flag("br_pd", 1'b0, status.pdown);
        cyc(1);
        eng_busy = 1'b0;
        $display("test busy_release done");
    endtask

    // main sequence
    initial begin
        miscompares = 0;
        checks = 0;
        n_res = 0;
        nrst = 1'b0;
        eng_busy = 1'b0;
        eng_chip = 1'b0;
        cyc(10);
        nrst = 1'b1;
        cyc(2);
        cmp_flag("up_pd", 1'b0, status.pdown);
        cmp_flag("up_sus", 1'b0, status.suspend_status_flag);
        t_suspend_resume();
        t_power_loss();
        t_ids();
        t_power_down();
        t_busy_release();
        tally_and_finish();
    end
endmodule // tb_flash_resume_powerdown_id
